//--- port_c_regs.vh
// register offsets, field positions and reset values of the port c block
`ifndef PORT_C_REGS_VH
`define PORT_C_REGS_VH

`define PC_ADDR_W 4
`define PC_ADDR_PIN_VALUE 4'h0
`define PC_ADDR_OUT_LATCH 4'h1
`define PC_ADDR_DIRECTION 4'h2
`define PC_ADDR_ANALOG_CFG 4'h3
`define PC_ADDR_CONTROL 4'h4
`define PC_ADDR_STATUS 4'h5

`define PC_DIR_RESET 8'hcf
`define PC_DIR_MASK 8'hcf
`define PC_LAT_RESET 8'h00
`define PC_ANCFG_RESET 8'h00
`define PC_CTRL_RESET 8'h00
`define PC_CTRL_MASK 8'h03

`define PC_ANCFG_CHAN11_BIT 3
`define PC_CTRL_OSC_EN_BIT 0
`define PC_CTRL_ONCHIP_XCVR_BIT 1

`define PC_PIN_OSC_OUT 0
`define PC_PIN_OSC_IN 1
`define PC_PIN_ANALOG 2
`define PC_PIN_XCVR_LO 4
`define PC_PIN_XCVR_HI 5

`endif

//--- port_c_pin_cell.v
// one port c pin: direction arbitration, registered pin drive and input sample
`timescale 1ns/1ps
module port_c_pin_cell #(
  parameter HAS_DIR = 1
) (
  input wire clk,
  input wire srst,
  input wire dir_bit,
  input wire lat_bit,
  input wire alt_en,
  input wire alt_data,
  input wire force_out,
  input wire force_in,
  input wire force_data,
  input wire dig_off,
  input wire pin_i,
  output reg pin_o_q,
  output reg pin_oe_n_q,
  output reg pin_sample_q,
  output wire drive_now
);

  wire dir_eff;
  wire drive_d;
  wire data_d;

  // a pin without a direction bit is an input unless something forces it out
  assign dir_eff = (HAS_DIR != 0) ? dir_bit : 1'b1;

  // disabled digital wins, then forced input, then forced output, then the
  // stored direction; a forced input is safer than contention on the wire
  assign drive_d = ~dig_off & ~force_in & (force_out | ~dir_eff);
  assign data_d = force_out ? force_data : (alt_en ? alt_data : lat_bit);
  assign drive_now = drive_d;

  // drive registered so the pad never sees decode glitches
  always @(posedge clk) begin
    if (srst) begin
      pin_o_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
      pin_sample_q <= 1'b0;
    end else begin
      pin_o_q <= drive_d ? data_d : 1'b0;
      pin_oe_n_q <= ~drive_d;
      pin_sample_q <= pin_i;
    end
  end

endmodule

//--- port_c_gpio.v
// eight-bit bidirectional general-purpose port c with peripheral overrides
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "port_c_regs.vh"
//
// Contract
// - eight pins, each with its own latch and pin-value bit; all but four and five have a direction bit.
// - direction bit one puts the pin driver in high impedance.
// - direction bit zero drives the pin from its output latch bit.
// - reading the latch register returns the latch, not the pin level.
// - an enabled peripheral may force a pin to output or input.
// - the direction register reads back what software stored, despite overrides.
// - pins four and five have no direction bits; as port pins only inputs.
// - external transceiver keeps pins four, five inputs; on-chip follows its operation.
// - after reset all pins but two are digital inputs.
// - pin two resets to analog input, chosen in the analog config register.
// - oscillator enabled gives pins zero and one to it, digital off.
// - pins zero to two carry remappable functions, in or out by direction.
// - pin two is converter channel eleven while it is analog.
//
module port_c_gpio (
  input wire clk,
  input wire srst,
  input wire [`PC_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata_q,
  input wire [7:0] pin_i,
  output wire [7:0] pin_o,
  output wire [7:0] pin_oe_n,
  input wire [7:0] periph_force_out,
  input wire [7:0] periph_force_in,
  input wire [7:0] periph_out_data,
  input wire [2:0] remap_out_en,
  input wire [2:0] remap_out_data,
  output wire remap_pin_eleven,
  output wire remap_pin_twelve,
  output wire remap_pin_thirteen,
  output wire counter_clock_in,
  input wire xcvr_tx_active,
  input wire [1:0] xcvr_tx_data,
  output wire [1:0] xcvr_rx_data,
  output wire lowfreq_osc_en,
  output wire analog_channel_eleven
);

  // software-visible state
  reg [7:0] c_port_output_latch_q;
  reg [7:0] c_port_direction_q;
  reg [7:0] analog_config_second_q;
  reg [7:0] control_q;

  // per-pin arbitration inputs and results
  wire [7:0] pin_sample;
  wire [7:0] drive_now;
  wire [7:0] dig_off;
  wire [7:0] force_out;
  wire [7:0] force_in;
  wire [7:0] force_data;
  wire [7:0] alt_en;
  wire [7:0] alt_data;
  wire [7:0] c_port_pin_value;
  wire [7:0] status_word;
  wire chan_eleven_digital_select;
  wire osc_on;
  wire onchip_xcvr;
  wire xcvr_drive;
  reg [7:0] rdata_d;

  // register decodes
  wire wr_pin;
  wire wr_lat;
  wire wr_dir;
  wire wr_ancfg;
  wire wr_ctrl;

  assign wr_pin = wr_stb & (addr == `PC_ADDR_PIN_VALUE);
  assign wr_lat = wr_stb & (addr == `PC_ADDR_OUT_LATCH);
  assign wr_dir = wr_stb & (addr == `PC_ADDR_DIRECTION);
  assign wr_ancfg = wr_stb & (addr == `PC_ADDR_ANALOG_CFG);
  assign wr_ctrl = wr_stb & (addr == `PC_ADDR_CONTROL);

  // field pick-outs
  assign chan_eleven_digital_select = analog_config_second_q[`PC_ANCFG_CHAN11_BIT];
  assign osc_on = control_q[`PC_CTRL_OSC_EN_BIT];
  assign onchip_xcvr = control_q[`PC_CTRL_ONCHIP_XCVR_BIT];

  // output latch, one bit per pin
  // pin-value write lands in the latch
  always @(posedge clk) begin
    if (srst) begin
      c_port_output_latch_q <= `PC_LAT_RESET;
    end else if (wr_lat | wr_pin) begin
      c_port_output_latch_q <= wdata;
    end
  end

  // reset direction to inputs everywhere a direction bit exists
  // bits four and five are not stored and stay zero
  always @(posedge clk) begin
    if (srst) begin
      c_port_direction_q <= `PC_DIR_RESET;
    end else if (wr_dir) begin
      c_port_direction_q <= wdata & `PC_DIR_MASK;
    end
  end

  // analog config resets with pin two analog
  always @(posedge clk) begin
    if (srst) begin
      analog_config_second_q <= `PC_ANCFG_RESET;
    end else if (wr_ancfg) begin
      analog_config_second_q <= wdata;
    end
  end

  // oscillator enable and transceiver select
  always @(posedge clk) begin
    if (srst) begin
      control_q <= `PC_CTRL_RESET;
    end else if (wr_ctrl) begin
      control_q <= wdata & `PC_CTRL_MASK;
    end
  end

  // oscillator owns pins zero and one, digital path off
  assign dig_off[`PC_PIN_OSC_OUT] = osc_on;
  assign dig_off[`PC_PIN_OSC_IN] = osc_on;
  // channel eleven select bit makes pin two digital
  // otherwise pin two stays an analog input
  assign dig_off[`PC_PIN_ANALOG] = ~chan_eleven_digital_select;
  assign dig_off[3] = 1'b0;
  assign dig_off[`PC_PIN_XCVR_LO] = 1'b0;
  assign dig_off[`PC_PIN_XCVR_HI] = 1'b0;
  assign dig_off[7:6] = 2'h0;

  // only the on-chip transceiver while sending drives pins four, five
  assign xcvr_drive = onchip_xcvr & xcvr_tx_active;

  // peripheral overrides; pins four, five take the transceiver instead
  assign force_out[3:0] = periph_force_out[3:0];
  assign force_out[`PC_PIN_XCVR_LO] = xcvr_drive;
  assign force_out[`PC_PIN_XCVR_HI] = xcvr_drive;
  assign force_out[7:6] = periph_force_out[7:6];
  assign force_in[3:0] = periph_force_in[3:0];
  assign force_in[5:4] = 2'h0;
  assign force_in[7:6] = periph_force_in[7:6];
  assign force_data[3:0] = periph_out_data[3:0];
  assign force_data[5:4] = xcvr_tx_data;
  assign force_data[7:6] = periph_out_data[7:6];

  // remappable outputs on pins zero to two, used only with direction 0
  assign alt_en[2:0] = remap_out_en;
  assign alt_en[7:3] = 5'h00;
  assign alt_data[2:0] = remap_out_data;
  assign alt_data[7:3] = 5'h00;

  // one cell per pin, spelled out so each pin's role reads at a glance
  // direction one leaves the pin undriven
  // direction zero drives the latch bit
  // pin zero: oscillator output, counter input, remap eleven
  port_c_pin_cell u_cell_0 (
    .clk(clk),
    .srst(srst),
    .dir_bit(c_port_direction_q[0]),
    .lat_bit(c_port_output_latch_q[0]),
    .alt_en(alt_en[0]),
    .alt_data(alt_data[0]),
    .force_out(force_out[0]),
    .force_in(force_in[0]),
    .force_data(force_data[0]),
    .dig_off(dig_off[0]),
    .pin_i(pin_i[0]),
    .pin_o_q(pin_o[0]),
    .pin_oe_n_q(pin_oe_n[0]),
    .pin_sample_q(pin_sample[0]),
    .drive_now(drive_now[0])
  );
  // pin one: oscillator input, remap twelve
  port_c_pin_cell u_cell_1 (
    .clk(clk),
    .srst(srst),
    .dir_bit(c_port_direction_q[1]),
    .lat_bit(c_port_output_latch_q[1]),
    .alt_en(alt_en[1]),
    .alt_data(alt_data[1]),
    .force_out(force_out[1]),
    .force_in(force_in[1]),
    .force_data(force_data[1]),
    .dig_off(dig_off[1]),
    .pin_i(pin_i[1]),
    .pin_o_q(pin_o[1]),
    .pin_oe_n_q(pin_oe_n[1]),
    .pin_sample_q(pin_sample[1]),
    .drive_now(drive_now[1])
  );
  // pin two: converter channel eleven or digital, remap thirteen
  port_c_pin_cell u_cell_2 (
    .clk(clk),
    .srst(srst),
    .dir_bit(c_port_direction_q[2]),
    .lat_bit(c_port_output_latch_q[2]),
    .alt_en(alt_en[2]),
    .alt_data(alt_data[2]),
    .force_out(force_out[2]),
    .force_in(force_in[2]),
    .force_data(force_data[2]),
    .dig_off(dig_off[2]),
    .pin_i(pin_i[2]),
    .pin_o_q(pin_o[2]),
    .pin_oe_n_q(pin_oe_n[2]),
    .pin_sample_q(pin_sample[2]),
    .drive_now(drive_now[2])
  );
  // pin three: plain port pin with peripheral overrides
  port_c_pin_cell u_cell_3 (
    .clk(clk),
    .srst(srst),
    .dir_bit(c_port_direction_q[3]),
    .lat_bit(c_port_output_latch_q[3]),
    .alt_en(alt_en[3]),
    .alt_data(alt_data[3]),
    .force_out(force_out[3]),
    .force_in(force_in[3]),
    .force_data(force_data[3]),
    .dig_off(dig_off[3]),
    .pin_i(pin_i[3]),
    .pin_o_q(pin_o[3]),
    .pin_oe_n_q(pin_oe_n[3]),
    .pin_sample_q(pin_sample[3]),
    .drive_now(drive_now[3])
  );
  // pin four, transceiver line, built without direction
  port_c_pin_cell #(
    .HAS_DIR(0)
  ) u_cell_4 (
    .clk(clk),
    .srst(srst),
    .dir_bit(c_port_direction_q[4]),
    .lat_bit(c_port_output_latch_q[4]),
    .alt_en(alt_en[4]),
    .alt_data(alt_data[4]),
    .force_out(force_out[4]),
    .force_in(force_in[4]),
    .force_data(force_data[4]),
    .dig_off(dig_off[4]),
    .pin_i(pin_i[4]),
    .pin_o_q(pin_o[4]),
    .pin_oe_n_q(pin_oe_n[4]),
    .pin_sample_q(pin_sample[4]),
    .drive_now(drive_now[4])
  );
  // pin five, transceiver line, built without direction
  port_c_pin_cell #(
    .HAS_DIR(0)
  ) u_cell_5 (
    .clk(clk),
    .srst(srst),
    .dir_bit(c_port_direction_q[5]),
    .lat_bit(c_port_output_latch_q[5]),
    .alt_en(alt_en[5]),
    .alt_data(alt_data[5]),
    .force_out(force_out[5]),
    .force_in(force_in[5]),
    .force_data(force_data[5]),
    .dig_off(dig_off[5]),
    .pin_i(pin_i[5]),
    .pin_o_q(pin_o[5]),
    .pin_oe_n_q(pin_oe_n[5]),
    .pin_sample_q(pin_sample[5]),
    .drive_now(drive_now[5])
  );
  // pin six: plain port pin with peripheral overrides
  port_c_pin_cell u_cell_6 (
    .clk(clk),
    .srst(srst),
    .dir_bit(c_port_direction_q[6]),
    .lat_bit(c_port_output_latch_q[6]),
    .alt_en(alt_en[6]),
    .alt_data(alt_data[6]),
    .force_out(force_out[6]),
    .force_in(force_in[6]),
    .force_data(force_data[6]),
    .dig_off(dig_off[6]),
    .pin_i(pin_i[6]),
    .pin_o_q(pin_o[6]),
    .pin_oe_n_q(pin_oe_n[6]),
    .pin_sample_q(pin_sample[6]),
    .drive_now(drive_now[6])
  );
  // pin seven: plain port pin with peripheral overrides
  port_c_pin_cell u_cell_7 (
    .clk(clk),
    .srst(srst),
    .dir_bit(c_port_direction_q[7]),
    .lat_bit(c_port_output_latch_q[7]),
    .alt_en(alt_en[7]),
    .alt_data(alt_data[7]),
    .force_out(force_out[7]),
    .force_in(force_in[7]),
    .force_data(force_data[7]),
    .dig_off(dig_off[7]),
    .pin_i(pin_i[7]),
    .pin_o_q(pin_o[7]),
    .pin_oe_n_q(pin_oe_n[7]),
    .pin_sample_q(pin_sample[7]),
    .drive_now(drive_now[7])
  );

  // pins with digital off read zero
  assign c_port_pin_value = pin_sample & ~dig_off;

  // remappable inputs see the pin level only while digital is on
  assign remap_pin_eleven = c_port_pin_value[0];
  assign remap_pin_twelve = c_port_pin_value[1];
  assign remap_pin_thirteen = c_port_pin_value[2];
  // counter input shares pin zero
  assign counter_clock_in = c_port_pin_value[0];
  // receive path from the transceiver pins
  assign xcvr_rx_data = c_port_pin_value[5:4];

  // tell the oscillator it owns its pins
  assign lowfreq_osc_en = osc_on;
  // pin two is routed to converter channel eleven while analog
  assign analog_channel_eleven = ~chan_eleven_digital_select;

  // status shows which pins the cells will drive from the next clock edge on
  assign status_word = drive_now;

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 8'h00;
    case (addr)
      `PC_ADDR_PIN_VALUE: rdata_d = c_port_pin_value;
      `PC_ADDR_OUT_LATCH: rdata_d = c_port_output_latch_q;
      // stored direction, overrides not visible here
      `PC_ADDR_DIRECTION: rdata_d = c_port_direction_q;
      `PC_ADDR_ANALOG_CFG: rdata_d = analog_config_second_q;
      `PC_ADDR_CONTROL: rdata_d = control_q;
      `PC_ADDR_STATUS: rdata_d = status_word;
      default: rdata_d = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (rd_stb) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

endmodule

//--- port_c_pin_world.sv
// pad-side circuitry for the port c block
`timescale 1ns/1ps
module port_c_pin_world (
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe_n,
  input wire [7:0] ext_val,
  output wire [7:0] pin_i
);
  // a pad driven by the block shows its data, otherwise the outside source wins
  assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext_val);
endmodule

//--- port_c_gpio_checker.sv
// port-level assertions for the port c block
`timescale 1ns/1ps
module port_c_gpio_checker (
  input wire clk,
  input wire srst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata_q,
  input wire [7:0] pin_oe_n,
  input wire [7:0] periph_force_in,
  input wire xcvr_tx_active,
  input wire lowfreq_osc_en,
  input wire analog_channel_eleven
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // write one place, read the same or another in the very next cycle
  sequence wr_rd(w, r);
    wr_stb && addr == w ##1 rd_stb && addr == r;
  endsequence
  a_latch_readback: assert property (wr_rd(1, 1) |=> rdata_q == $past(wdata, 2))
    else $error("latch readback");
  a_pinval_write: assert property (wr_rd(0, 1) |=> rdata_q == $past(wdata, 2))
    else $error("pin value write");
  a_dir_back: assert property (wr_rd(2, 2) |=> rdata_q == ($past(wdata, 2) & 8'hcf))
    else $error("direction readback");
  // read data stand only in the cycle after a strobe
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata_q == 8'h00)
    else $error("stray read data");
  a_xcvr_input: assert property (!$past(xcvr_tx_active) |-> pin_oe_n[5:4] == 2'h3)
    else $error("pins four five driven");
  a_force_in: assert property (&(pin_oe_n | ~($past(periph_force_in) & 8'hcf)))
    else $error("forced input driven");
  a_osc_pins: assert property (lowfreq_osc_en && $past(lowfreq_osc_en) |-> &pin_oe_n[1:0])
    else $error("oscillator pins driven");
  a_chan_select: assert property ($past(wr_stb) && $past(addr) == 4'h3 |->
    analog_channel_eleven == !$past(wdata[3])) else $error("channel select");
endmodule
bind port_c_gpio port_c_gpio_checker port_c_gpio_checker_i (.clk(clk), .srst(srst),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
  .pin_oe_n(pin_oe_n), .periph_force_in(periph_force_in), .xcvr_tx_active(xcvr_tx_active),
  .lowfreq_osc_en(lowfreq_osc_en), .analog_channel_eleven(analog_channel_eleven));

//--- tb_port_c_gpio.sv
// self-checking bench for the port c block
`timescale 1ns/1ps
module tb_port_c_gpio;
  reg clk = 0, srst = 1, wr_stb = 0, rd_stb = 0, xa, i_xa = 0;
  reg [3:0] addr = 0;
  reg [7:0] wdata = 0, fo, fi, pod, ext, i_fo = 0, i_fi = 0, i_pod = 0, i_ext = 0;
  reg [7:0] dir, lat, anc, ctl, dv, e_o, offm, pv;
  reg [2:0] ren, rdat, i_ren = 0, i_rdat = 0;
  reg [1:0] xd, i_xd = 0;
  integer errors = 0, n_compared = 0, k, j;
  wire [7:0] rdata_q, pin_i, pin_o, pin_oe_n;
  wire [1:0] rx;
  wire r11, r12, r13, cci, osc, ch_ana;
  initial begin
    forever #50 clk = ~clk;
  end
  port_c_gpio port_c_gpio_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .periph_force_out(i_fo), .periph_force_in(i_fi),
    .periph_out_data(i_pod), .remap_out_en(i_ren), .remap_out_data(i_rdat),
    .remap_pin_eleven(r11), .remap_pin_twelve(r12), .remap_pin_thirteen(r13),
    .counter_clock_in(cci), .xcvr_tx_active(i_xa), .xcvr_tx_data(i_xd), .xcvr_rx_data(rx),
    .lowfreq_osc_en(osc), .analog_channel_eleven(ch_ana));
  port_c_pin_world port_c_pin_world_i (.pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .ext_val(i_ext), .pin_i(pin_i));
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // read data compare, kept apart from the pin-side compare
  task cmp_rd(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: read got %h want %h", $time, got, exp);
      end
    end
  endtask
  // strobe left high so a read may follow with no gap
  task wr(input [3:0] a, input [7:0] d);
    begin
      wr_stb <= 1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      wr_stb <= 0;
      rd_stb <= 1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 0;
      #1 cmp_rd(rdata_q, e);
      @(posedge clk);
    end
  endtask
  task wrap_up;
    begin
      if (errors == 0 && n_compared > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // drive priority, returns drive mask and pad data
  function automatic [15:0] exp_pins();
    reg [7:0] d, t;
    begin
      d = 8'h00;
      t = 8'h00;
      for (j = 0; j < 8; j = j + 1) begin
        if (j == 4 || j == 5) begin
          d[j] = ctl[1] & xa;
          t[j] = xd[j-4];
        end else if (!offm[j] && !fi[j]) begin
          d[j] = fo[j] | ~dir[j];
          t[j] = fo[j] ? pod[j] : (j < 3 && ren[j]) ? rdat[j] : lat[j];
        end
      end
      exp_pins = {d, t & d};
    end
  endfunction
  // reset state, unmapped access, then random setups with corners first
  initial begin
    k = $urandom(32);
    repeat (12) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    #1 cmp(pin_oe_n, 8'hff);
    cmp({7'h00, ch_ana}, 8'h01);
    @(posedge clk);
    wr(4'hf, 8'hff);
    rd(4'h2, 8'hcf);
    rd(4'h3, 8'h00);
    rd(4'hf, 8'h00);
    for (k = 0; k < 40; k = k + 1) begin
      {dir, lat, anc, ctl} = $urandom;
      {fo, fi, pod, ext} = $urandom;
      {ren, rdat, xd, xa} = 9'($urandom);
      ctl = ctl & 8'h03;
      case (k)
        0: {fo, fi, dir, ctl, anc} = 40'h0000000008;
        1: {fo, fi} = 16'hffff;
        2: {dir, ctl, xa} = 17'h1fe05;
        3: {fo, ctl} = 16'hff01;
      endcase
      offm = {5'h00, ~anc[3], ctl[0], ctl[0]};
      {i_fo, i_fi, i_pod, i_ext} <= {fo, fi, pod, ext};
      {i_ren, i_rdat, i_xd, i_xa} <= {ren, rdat, xd, xa};
      wr(4'h4, ctl);
      wr(4'h3, anc);
      wr(4'h2, dir);
      rd(4'h2, dir & 8'hcf);
      wr({3'h0, ~k[0]}, lat);
      rd(4'h1, lat);
      @(posedge clk);
      {dv, e_o} = exp_pins();
      pv = ((dv & e_o) | (~dv & ext)) & ~offm;
      #1 cmp(pin_oe_n, ~dv);
      cmp(pin_o, e_o);
      cmp({rx, cci, r13, r12, r11, ch_ana, osc}, {pv[5:4], pv[0], pv[2:0], ~anc[3], ctl[0]});
      @(posedge clk);
      rd(4'h0, pv);
      rd(4'h5, dv);
    end
    wrap_up;
  end
  // bound well above the few hundred cycles the tests need
  initial begin
    #500000;
    errors = errors + 1;
    wrap_up;
  end
endmodule
